// File: cabe_exec.sv
// execution core for and/add, bit clear, bit test skip and relative jump
// Summary of operation
// - and_acc_file ands accumulator with file, Z only
// - destination bit 0 accumulator, 1 file register
// - add_acc_file adds, updates both carries and Z
// - add_acc_file_carry also adds carry in
// - carry add result obeys destination bit
// - bit_clear_file clears one bit, flags untouched
// - skip_if_bit_clear: zero bit discards next instruction
// - relative_jump adds signed offset, two cycles
// - jump target is own address plus one plus offset
// - skip_if_bit_set: one bit discards next instruction
`timescale 1ns/1ps

module cabe_exec
   import cabe_pkg::*;
(
   input  wire logic               i_sys_clk,
   input  wire logic               i_rst_n,
   input  wire logic               i_instr_valid,
   input  wire logic [INSTR_W-1:0] i_instr,
   output logic                    o_instr_ready,
   output logic                    o_skip_pending,
   output logic [DATA_W-1:0]       o_acc,
   output logic [ST_W-1:0]         o_status,
   output logic [PC_W-1:0]         o_pc,
   input  wire logic [BUS_AW-1:0]  i_addr,
   input  wire logic [BUS_DW-1:0]  i_wdata,
   input  wire logic               i_wr_en,
   input  wire logic               i_rd_en,
   output logic [BUS_DW-1:0]       o_rdata
);

   typedef enum {ST_RUN, ST_JUMP} cabe_state_t;

   cabe_alu_if alu ();
   cabe_pc_if  pcu ();

   cabe_alu u_alu (
      .u (alu.unit)
   );

   cabe_pc u_pc (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .u         (pcu.unit)
   );

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   cabe_state_t         state_r;
   cabe_state_t         state_nxt;
   logic [DATA_W-1:0]   acc_r;
   logic [DATA_W-1:0]   acc_nxt;
   logic [ST_W-1:0]     st_r;
   logic [ST_W-1:0]     st_nxt;
   logic                skip_r;
   logic                skip_nxt;
   logic [BUS_DW-1:0]   rdata_r;
   logic [BUS_DW-1:0]   rdata_nxt;
   logic [DATA_W-1:0]   mem_r [MEM_DEPTH];
   logic                mem_we;
   logic [FILE_AW-1:0]  mem_wa;
   logic [DATA_W-1:0]   mem_wd;

   // ----------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------
   logic               accept;
   logic               go;
   logic               is_and;
   logic               is_add;
   logic               is_addc;
   logic               is_bclr;
   logic               is_skclr;
   logic               is_skset;
   logic               is_jump;
   logic               is_arith;
   logic               dest_file;
   logic [FILE_AW-1:0] f_addr;
   logic [BIT_IW-1:0]  b_idx;
   logic [DATA_W-1:0]  file_val;
   logic [DATA_W-1:0]  bit_mask;
   logic               bus_mem;
   logic [FILE_AW-1:0] bus_idx;

   assign o_instr_ready = (state_r == ST_RUN);
   assign accept    = i_instr_valid & o_instr_ready;
   assign go        = accept & ~skip_r;
   assign is_and    = (i_instr & OPM_FILE) == OP_AND;
   assign is_add    = (i_instr & OPM_FILE) == OP_ADD;
   assign is_addc   = (i_instr & OPM_FILE) == OP_ADDC;
   assign is_bclr   = (i_instr & OPM_BIT) == OP_BCLR;
   assign is_skclr  = (i_instr & OPM_BIT) == OP_SKCLR;
   assign is_skset  = (i_instr & OPM_BIT) == OP_SKSET;
   assign is_jump   = (i_instr & OPM_JUMP) == OP_JUMP;
   assign is_arith  = is_and | is_add | is_addc;
   assign dest_file = i_instr[D_POS];
   assign f_addr    = i_instr[F_LSB +: FILE_AW];
   assign b_idx     = i_instr[B_LSB +: BIT_IW];
   assign file_val  = mem_r[f_addr];
   assign bit_mask  = DATA_W'(1) << b_idx;
   assign bus_mem   = i_addr[A_MEM_BIT] & (i_addr[1:0] == 2'h0);
   assign bus_idx   = i_addr[2 +: FILE_AW];

   always_comb begin
      alu.acc      = acc_r;
      alu.file     = file_val;
      alu.carry_in = st_r[ST_C];
      if (is_addc) begin
         alu.op = ALU_ADDC;
      end else if (is_add) begin
         alu.op = ALU_ADD;
      end else begin
         alu.op = ALU_AND;
      end
   end

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      state_nxt   = state_r;
      acc_nxt     = acc_r;
      st_nxt      = st_r;
      skip_nxt    = skip_r;
      mem_we      = 1'b0;
      mem_wa      = bus_idx;
      mem_wd      = i_wdata[DATA_W-1:0];
      pcu.inc     = 1'b0;
      pcu.rel_load = 1'b0;
      pcu.offset  = i_instr[K_LSB +: REL_W];
      pcu.sw_load = 1'b0;
      pcu.sw_val  = i_wdata[PC_W-1:0];
      // software writes first so that a retiring instruction overrides them
      if (i_wr_en) begin
         if (i_addr == A_ACC) begin
            acc_nxt = i_wdata[DATA_W-1:0];
         end
         if (i_addr == A_STATUS) begin
            st_nxt = i_wdata[ST_W-1:0];
         end
         if (i_addr == A_PC) begin
            pcu.sw_load = 1'b1;
         end
         if (bus_mem) begin
            mem_we = 1'b1;
         end
      end
      unique case (state_r)
         ST_JUMP: begin
            state_nxt = ST_RUN;
         end
         ST_RUN: begin
            if (accept && skip_r) begin
               // discarded instruction retires as a no-operation
               skip_nxt = 1'b0;
               pcu.inc  = 1'b1;
            end else if (go && is_jump) begin
               pcu.rel_load = 1'b1;
               state_nxt    = ST_JUMP;
            end else if (go) begin
               pcu.inc = 1'b1;
               if (is_arith) begin
                  if (dest_file) begin
                     mem_we = 1'b1;
                     mem_wa = f_addr;
                     mem_wd = alu.result;
                  end else begin
                     acc_nxt = alu.result;
                  end
                  st_nxt[ST_Z] = alu.zero;
                  if (!is_and) begin
                     st_nxt[ST_C]  = alu.carry;
                     st_nxt[ST_NIB] = alu.nib_carry;
                  end
               end
               if (is_bclr) begin
                  mem_we = 1'b1;
                  mem_wa = f_addr;
                  mem_wd = file_val & ~bit_mask;
               end
               if (is_skclr) begin
                  skip_nxt = ~file_val[b_idx];
               end
               if (is_skset) begin
                  skip_nxt = file_val[b_idx];
               end
            end
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // register port read
   // ----------------------------------------------------------------------
   always_comb begin
      rdata_nxt = '0;
      if (i_rd_en) begin
         if (i_addr == A_ACC) begin
            rdata_nxt = {{(BUS_DW-DATA_W){1'b0}}, acc_r};
         end else if (i_addr == A_STATUS) begin
            rdata_nxt = {{(BUS_DW-ST_W){1'b0}}, st_r};
         end else if (i_addr == A_PC) begin
            rdata_nxt = {{(BUS_DW-PC_W){1'b0}}, pcu.pc};
         end else if (bus_mem) begin
            rdata_nxt = {{(BUS_DW-DATA_W){1'b0}}, mem_r[bus_idx]};
         end
      end
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state_r <= ST_RUN;
         acc_r   <= ACC_RST;
         st_r    <= STATUS_RST;
         skip_r  <= 1'b0;
         rdata_r <= '0;
      end else begin
         state_r <= state_nxt;
         acc_r   <= acc_nxt;
         st_r    <= st_nxt;
         skip_r  <= skip_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // data memory is not reset; software preloads it over the register port
   always_ff @(posedge i_sys_clk) begin
      if (mem_we) begin
         mem_r[mem_wa] <= mem_wd;
      end
   end

   assign o_acc          = acc_r;
   assign o_status       = st_r;
   assign o_pc           = pcu.pc;
   assign o_skip_pending = skip_r;
   assign o_rdata        = rdata_r;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   a_and_result: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      go && is_and && !dest_file |=> acc_r == ($past(acc_r) & $past(file_val))
         && st_r[ST_C] == $past(st_r[ST_C]) && st_r[ST_Z] == (acc_r == '0))
      else $error("and result or flags wrong");

   a_dest_file: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      go && is_arith && dest_file |=> $stable(acc_r)
         && mem_r[$past(f_addr)] == $past(alu.result))
      else $error("file destination not honoured");

   a_add_carry: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      go && is_add |=> st_r[ST_C] == ((9'($past(acc_r)) + 9'($past(file_val))) > 9'h0ff)
         && st_r[ST_NIB] == ((5'($past(acc_r[3:0])) + 5'($past(file_val[3:0]))) > 5'h0f))
      else $error("add carry flags wrong");

   a_addc_flags: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      go && is_addc |=> st_r[ST_C] == ((9'($past(acc_r)) + 9'($past(file_val))
         + 9'($past(st_r[ST_C]))) > 9'h0ff)
         && st_r[ST_NIB] == ((5'($past(acc_r[3:0])) + 5'($past(file_val[3:0]))
         + 5'($past(st_r[ST_C]))) > 5'h0f))
      else $error("carry add flags wrong");

   a_addc_file: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      go && is_addc && dest_file |=> $stable(acc_r) && mem_r[$past(f_addr)] ==
         8'($past(acc_r) + $past(file_val) + 8'($past(st_r[ST_C]))))
      else $error("carry add file destination wrong");

   a_zero_acc: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      go && is_arith && !dest_file |=> st_r[ST_Z] == (acc_r == '0))
      else $error("zero flag does not match result");

   a_addc_sum: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      go && is_addc && !dest_file |=> acc_r ==
         8'($past(acc_r) + $past(file_val) + 8'($past(st_r[ST_C]))))
      else $error("carry add sum wrong");

   a_bclr_bit: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      go && is_bclr |=> mem_r[$past(f_addr)] == ($past(file_val) & ~$past(bit_mask))
         && $stable(st_r) && $stable(acc_r))
      else $error("bit clear wrong");

   a_skip_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      go && is_skclr |=> skip_r == !$past(file_val[b_idx]))
      else $error("skip on clear wrong");

   a_skip_set: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      go && is_skset |=> skip_r == $past(file_val[b_idx]))
      else $error("skip on set wrong");

   a_skip_nop: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      accept && skip_r && !i_wr_en |=> !skip_r && $stable(acc_r) && $stable(st_r)
         && o_pc == $past(o_pc) + 15'h0001)
      else $error("discarded instruction had effect");

   a_jump_target: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      go && is_jump |=> o_pc == $past(o_pc) + 15'h0001
         + {{6{$past(i_instr[8])}}, $past(i_instr[8:0])})
      else $error("jump target wrong");

   a_jump_cycles: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      go && is_jump |=> !o_instr_ready && $stable(st_r) ##1 o_instr_ready)
      else $error("jump did not take two cycles");

   a_dead_once: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !o_instr_ready |=> o_instr_ready)
      else $error("dead cycle longer than one");

endmodule : cabe_exec

// File: cabe_pkg.sv
// shared constants and types for the arithmetic, bit and branch execution block
package cabe_pkg;

   // ----------------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------------
   localparam int DATA_W  = 8;
   localparam int PC_W    = 15;
   localparam int FILE_AW = 7;
   localparam int BIT_IW  = 3;
   localparam int REL_W   = 9;
   localparam int INSTR_W = 14;
   localparam int NIB_W   = 4;
   localparam int BUS_AW  = 10;
   localparam int BUS_DW  = 32;
   localparam int MEM_DEPTH = 128;

   // ----------------------------------------------------------------------
   // opcode match values and masks
   // ----------------------------------------------------------------------
   localparam logic [INSTR_W-1:0] OPM_FILE  = 14'h3f00;
   localparam logic [INSTR_W-1:0] OP_AND    = 14'h0500;
   localparam logic [INSTR_W-1:0] OP_ADD    = 14'h0700;
   localparam logic [INSTR_W-1:0] OP_ADDC   = 14'h3d00;
   localparam logic [INSTR_W-1:0] OPM_BIT   = 14'h3c00;
   localparam logic [INSTR_W-1:0] OP_BCLR   = 14'h1000;
   localparam logic [INSTR_W-1:0] OP_SKCLR  = 14'h1800;
   localparam logic [INSTR_W-1:0] OP_SKSET  = 14'h1c00;
   localparam logic [INSTR_W-1:0] OPM_JUMP  = 14'h3e00;
   localparam logic [INSTR_W-1:0] OP_JUMP   = 14'h3200;

   // operand field positions
   localparam int F_LSB = 0;
   localparam int D_POS = 7;
   localparam int B_LSB = 7;
   localparam int K_LSB = 0;

   // status bit positions
   localparam int ST_C   = 0;
   localparam int ST_NIB = 1;
   localparam int ST_Z   = 2;
   localparam int ST_W   = 3;

   // ----------------------------------------------------------------------
   // register port map and reset values
   // ----------------------------------------------------------------------
   localparam logic [BUS_AW-1:0] A_ACC      = 10'h000;
   localparam logic [BUS_AW-1:0] A_STATUS   = 10'h004;
   localparam logic [BUS_AW-1:0] A_PC       = 10'h008;
   localparam int                A_MEM_BIT  = 9;
   localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;
   localparam logic [ST_W-1:0]   STATUS_RST = 3'h0;
   localparam logic [PC_W-1:0]   PC_RST     = 15'h0000;

   typedef enum logic [1:0] {ALU_AND, ALU_ADD, ALU_ADDC} cabe_alu_op_t;

endpackage : cabe_pkg

// File: cabe_if.sv
// interfaces between the execution core, its adder unit and its program counter
`timescale 1ns/1ps

interface cabe_alu_if;
   import cabe_pkg::*;
   logic [DATA_W-1:0] acc;
   logic [DATA_W-1:0] file;
   logic              carry_in;
   cabe_alu_op_t      op;
   logic [DATA_W-1:0] result;
   logic              carry;
   logic              nib_carry;
   logic              zero;
   modport core (output acc, file, carry_in, op, input result, carry, nib_carry, zero);
   modport unit (input acc, file, carry_in, op, output result, carry, nib_carry, zero);
endinterface : cabe_alu_if

interface cabe_pc_if;
   import cabe_pkg::*;
   logic             inc;
   logic             rel_load;
   logic [REL_W-1:0] offset;
   logic             sw_load;
   logic [PC_W-1:0]  sw_val;
   logic [PC_W-1:0]  pc;
   modport core (output inc, rel_load, offset, sw_load, sw_val, input pc);
   modport unit (input inc, rel_load, offset, sw_load, sw_val, output pc);
endinterface : cabe_pc_if

// File: cabe_alu.sv
// combinational and/add unit with carry, nibble carry and zero outputs
`timescale 1ns/1ps

module cabe_alu
   import cabe_pkg::*;
(
   cabe_alu_if.unit u
);

   logic [DATA_W:0] sum;
   logic [NIB_W:0]  nib;
   logic            cin;

   // ----------------------------------------------------------------------
   // datapath
   // ----------------------------------------------------------------------
   always_comb begin
      cin = (u.op == ALU_ADDC) ? u.carry_in : 1'b0;
      sum = {1'b0, u.acc} + {1'b0, u.file} + {{DATA_W{1'b0}}, cin};
      nib = {1'b0, u.acc[NIB_W-1:0]} + {1'b0, u.file[NIB_W-1:0]} + {{NIB_W{1'b0}}, cin};
      if (u.op == ALU_AND) begin
         u.result = u.acc & u.file;
      end else begin
         u.result = sum[DATA_W-1:0];
      end
      u.carry     = sum[DATA_W];
      u.nib_carry = nib[NIB_W];
      u.zero      = (u.result == '0);
   end

endmodule : cabe_alu

// File: cabe_pc.sv
// program counter with increment, signed relative load and software load
`timescale 1ns/1ps

module cabe_pc
   import cabe_pkg::*;
(
   input  wire logic i_sys_clk,
   input  wire logic i_rst_n,
   cabe_pc_if.unit   u
);

   logic [PC_W-1:0] pc_r;
   logic [PC_W-1:0] pc_nxt;
   logic [PC_W-1:0] sext;

   always_comb begin
      sext   = {{(PC_W-REL_W){u.offset[REL_W-1]}}, u.offset};
      pc_nxt = pc_r;
      if (u.rel_load) begin
         // target is the jump's own counter value plus one plus the signed offset
         pc_nxt = pc_r + PC_W'(1) + sext;
      end else if (u.inc) begin
         pc_nxt = pc_r + PC_W'(1);
      end else if (u.sw_load) begin
         pc_nxt = u.sw_val;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         pc_r <= PC_RST;
      end else begin
         pc_r <= pc_nxt;
      end
   end

   assign u.pc = pc_r;

endmodule : cabe_pc

// File: cabe_tb.sv
// self-checking bench for the arithmetic, bit and branch execution core
`timescale 1ns/1ps

module testbench;
   import cabe_pkg::*;

   logic               sys_clk;
   logic               rst_n;
   logic               instr_valid;
   logic [INSTR_W-1:0] instr;
   logic               instr_ready;
   logic               skip_pending;
   logic [DATA_W-1:0]  acc;
   logic [ST_W-1:0]    status;
   logic [PC_W-1:0]    pc;
   logic [BUS_AW-1:0]  addr;
   logic [BUS_DW-1:0]  wdata;
   logic               wr_en;
   logic               rd_en;
   logic [BUS_DW-1:0]  rdata;
   int                 error_cnt;
   int                 num_checks;

   cabe_exec uut (
      .i_sys_clk      (sys_clk),
      .i_rst_n        (rst_n),
      .i_instr_valid  (instr_valid),
      .i_instr        (instr),
      .o_instr_ready  (instr_ready),
      .o_skip_pending (skip_pending),
      .o_acc          (acc),
      .o_status       (status),
      .o_pc           (pc),
      .i_addr         (addr),
      .i_wdata        (wdata),
      .i_wr_en        (wr_en),
      .i_rd_en        (rd_en),
      .o_rdata        (rdata)
   );

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // ----------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------
   task conclude;
      if (error_cnt == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task wr(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
      @(posedge sys_clk);
      wr_en <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe, so sample there
   task rd(input logic [BUS_AW-1:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1 d = rdata;
   endtask : rd

   task setm(input logic [6:0] f, input logic [7:0] v);
      wr({1'b1, f, 2'b00}, 32'(v));
   endtask : setm

   task getm(input logic [6:0] f, output logic [31:0] d);
      rd({1'b1, f, 2'b00}, d);
   endtask : getm

   // waits for ready in a settled cycle; nothing was offered meanwhile, so it stays up
   task exec(input logic [INSTR_W-1:0] w);
      int n;
      n = 0;
      @(posedge sys_clk);
      #1;
      while (instr_ready !== 1'b1) begin
         n++;
         if (n > 20) begin
            error_cnt++;
            $display("mismatch %0t ready never came", $time);
            conclude();
         end
         @(posedge sys_clk);
         #1;
      end
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      instr       <= w;
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      #1;
   endtask : exec

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task t_reset;
      logic [31:0] d;
      #1;
      chk(32'(acc), 32'h0, "acc reset");
      chk(32'(status), 32'h0, "status reset");
      chk(32'(pc), 32'h0, "pc reset");
      chk(32'(instr_ready), 32'h1, "ready reset");
      chk(32'(skip_pending), 32'h0, "skip reset");
      wr(A_ACC, 32'h5a);
      wr(10'h010, 32'hff);
      rd(A_ACC, d);
      chk(d, 32'h5a, "acc readback");
      @(posedge sys_clk);
      #1;
      chk(32'(rdata), 32'h0, "read data one cycle only");
      rd(10'h0fc, d);
      chk(d, 32'h0, "unmapped read");
   endtask : t_reset

   task t_and;
      logic [31:0] d;
      wr(A_ACC, 32'h0f);
      setm(7'd127, 8'hf0);
      wr(A_STATUS, 32'h3);
      exec(OP_AND | 14'd127);
      chk(32'(acc), 32'h0, "and to acc");
      chk(32'(status), 32'h7, "and zero flag only");
      wr(A_ACC, 32'h3c);
      setm(7'd0, 8'h35);
      exec(OP_AND | 14'h0080);
      chk(32'(acc), 32'h3c, "and acc kept");
      getm(7'd0, d);
      chk(d, 32'h34, "and to file");
      chk(32'(status), 32'h3, "and nonzero flags");
   endtask : t_and

   task add_case(input logic [INSTR_W-1:0] op, input logic [7:0] a, input logic [7:0] m,
                 input logic dst, input logic [6:0] f, input logic cin);
      logic [8:0]  s;
      logic [4:0]  nb;
      logic        c;
      logic [31:0] got;
      c  = (op == OP_ADDC) ? cin : 1'b0;
      s  = {1'b0, a} + {1'b0, m} + {8'h00, c};
      nb = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, c};
      wr(A_ACC, 32'(a));
      setm(f, m);
      wr(A_STATUS, {29'h0, 2'b00, cin});
      exec(op | {6'h00, dst, f});
      getm(f, got);
      chk(32'(acc), dst ? 32'(a) : 32'(s[7:0]), "add acc");
      chk(got, dst ? 32'(s[7:0]) : 32'(m), "add file");
      chk(32'(status), {29'h0, s[7:0] == 8'h00, nb[4], s[8]}, "add flags");
   endtask : add_case

   // clears accumulate, so each step checks the untouched upper bits too
   task t_bclr;
      logic [31:0] d;
      logic [7:0]  e;
      setm(7'd10, 8'hff);
      wr(A_STATUS, 32'h5);
      wr(A_ACC, 32'h81);
      for (int b = 0; b < 8; b++) begin
         exec(OP_BCLR | {4'h0, 3'(b), 7'd10});
         e = 8'hff << (b + 1);
         getm(7'd10, d);
         chk(d, 32'(e), "bit clear byte");
         chk(32'(status), 32'h5, "bit clear flags");
         chk(32'(acc), 32'h81, "bit clear acc");
      end
   endtask : t_bclr

   task t_skip;
      logic [PC_W-1:0] p;
      logic            sk;
      setm(7'd20, 8'ha5);
      setm(7'd21, 8'h01);
      for (int s = 0; s < 2; s++) begin
         for (int b = 0; b < 8; b++) begin
            sk = (s == 1) ? 8'ha5 >> b : ~(8'ha5 >> b);
            wr(A_ACC, 32'h10);
            #1;
            p = pc;
            exec(((s == 1) ? OP_SKSET : OP_SKCLR) | {4'h0, 3'(b), 7'd20});
            chk(32'(skip_pending), 32'(sk), "skip decision");
            exec(OP_ADD | 14'd21);
            chk(32'(acc), sk ? 32'h10 : 32'h11, "skipped instr");
            chk(32'(pc), 32'(p + 15'd2), "skip pc");
            chk(32'(skip_pending), 32'h0, "skip cleared");
         end
      end
   endtask : t_skip

   // a request held through the dead cycle must be taken exactly once
   task jump_case(input logic [8:0] k);
      logic [PC_W-1:0] e;
      logic [31:0]     d;
      wr(A_PC, 32'h1000);
      wr(A_STATUS, 32'h7);
      e = 15'h1001 + {{6{k[8]}}, k};
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      instr       <= OP_JUMP | {5'h00, k};
      @(posedge sys_clk);
      instr <= 14'h0000;
      #1;
      chk(32'(pc), 32'(e), "jump target");
      chk(32'(instr_ready), 32'h0, "jump dead cycle");
      @(posedge sys_clk);
      #1;
      chk(32'(pc), 32'(e), "dead cycle refused");
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      #1;
      chk(32'(pc), 32'(e + 15'd1), "after jump");
      chk(32'(status), 32'h7, "jump flags");
      rd(A_PC, d);
      chk(d, 32'(e + 15'd1), "pc readback");
      rd(A_STATUS, d);
      chk(d, 32'h7, "status readback");
   endtask : jump_case

   // ----------------------------------------------------------------------
   // main sequence and hang guard
   // ----------------------------------------------------------------------
   initial begin
      error_cnt   = 0;
      num_checks  = 0;
      rst_n       = 1'b0;
      instr_valid = 1'b0;
      instr       = 14'h0000;
      addr        = 10'h000;
      wdata       = 32'h0;
      wr_en       = 1'b0;
      rd_en       = 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_and();
      add_case(OP_ADD, 8'h88, 8'h78, 1'b0, 7'd3, 1'b1);
      add_case(OP_ADD, 8'h01, 8'h02, 1'b1, 7'd127, 1'b0);
      add_case(OP_ADDC, 8'hff, 8'h00, 1'b0, 7'd9, 1'b1);
      add_case(OP_ADDC, 8'h0f, 8'h01, 1'b1, 7'd64, 1'b0);
      add_case(OP_ADDC, 8'h27, 8'h18, 1'b1, 7'd0, 1'b1);
      t_bclr();
      t_skip();
      jump_case(9'h100);
      jump_case(9'h0ff);
      jump_case(9'h1ff);
      jump_case(9'h000);
      conclude();
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      $display("mismatch %0t run did not finish", $time);
      conclude();
   end

endmodule : testbench
